// >>> design/clkgen_cfg_pkg.sv
// package: offsets, fields, defaults and states of the clock generator bank
package clkgen_cfg_pkg;

    // ==========================================================
    // byte offsets of the configuration bank
    localparam logic [7:0] OFS_GATE = 8'h00; // output_gate_control
    localparam logic [7:0] OFS_SPREAD = 8'h01; // spread_and_swing_control
    localparam logic [7:0] OFS_EDGE = 8'h02; // diff_edge_rate_control
    localparam logic [7:0] OFS_REF = 8'h03; // reference_output_control
    localparam logic [7:0] OFS_IDENT = 8'h05; // revision_and_maker_code
    localparam logic [7:0] OFS_CLASS = 8'h06; // device_class_and_code
    localparam logic [7:0] OFS_LEN = 8'h07; // readback_length
    localparam logic [7:0] OFS_STOP = 8'h0b; // stop-state byte

    // ==========================================================
    // field positions
    localparam int POS_PIN_LO = 6; // spread_pin_readback bits 7:6
    localparam int POS_OVR = 5; // spread_software_override
    localparam int POS_SWAMT_LO = 3; // spread_software_amount bits 4:3
    localparam int POS_AMP_LO = 0; // amplitude bits 1:0
    localparam int POS_REFRATE_LO = 6; // reference edge rate bits 7:6
    localparam int POS_REFWAKE = 5; // reference runs in power-down
    localparam int POS_REFEN = 4; // reference enable

    // ==========================================================
    // values after reset
    localparam logic [3:0] RST_GATE = 4'hf;
    localparam logic RST_OVR = 1'b0;
    localparam logic [1:0] RST_SWAMT = 2'h0;
    localparam logic [1:0] RST_AMP = 2'h2;
    localparam logic [3:0] RST_EDGE = 4'hf;
    localparam logic [1:0] RST_REFRATE = 2'h1;
    localparam logic RST_REFWAKE = 1'b0;
    localparam logic RST_REFEN = 1'b1;
    localparam logic [4:0] RST_LEN = 5'h08;
    localparam logic [1:0] RST_STOP = 2'h0;

    // identity codes: values are arbitrary
    localparam logic [3:0] REVISION_CODE = 4'h3;
    localparam logic [3:0] MAKER_CODE = 4'h5;
    localparam logic [1:0] CLASS_CODE = 2'h2;
    localparam logic [5:0] PART_CODE = 6'h2a;

    // serial address of this device, arbitrary default
    localparam logic [6:0] SLAVE_ADDR = 7'h50;

    // ==========================================================
    // bit counter values of the serial byte engine
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [7:0] IDLE_BYTE = 8'hff; // released bus reads as ones

    // ==========================================================
    // transaction states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_INDEX = 3'b010,
        ST_COUNT = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101,
        ST_IGNORE = 3'b110
    } xfer_state_t;

endpackage

// >>> design/smbus_byte_link.sv
// serial byte engine: start/stop detection, byte shifting, acknowledge slot
`timescale 1ns/1ps
module smbus_byte_link
    import clkgen_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic ackEn,
    input wire logic txMode,
    input wire logic [7:0] txByte,
    output logic startSeen,
    output logic stopSeen,
    output logic byteDone,
    output logic [7:0] rxByte,
    output logic ackSeen,
    output logic hostAck
);

    typedef struct packed {
        logic sclQ;
        logic sdaQ;
        logic active;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic drive;
        logic byteDone;
        logic ackSeen;
        logic hostAck;
    } link_t;

    link_t q, d;
    logic sclRise, sclFall;

    // ==========================================================
    // bus events, taken from the previous sample of each line
    assign sclRise = scl && !q.sclQ;
    assign sclFall = !scl && q.sclQ;
    assign startSeen = scl && q.sclQ && q.sdaQ && !sdaIn;
    assign stopSeen = scl && q.sclQ && !q.sdaQ && sdaIn;

    // next state; data moves only on clock falls so the host
    // never sees sda change while scl is high
    always_comb begin
        d = q;
        d.sclQ = scl;
        d.sdaQ = sdaIn;
        d.byteDone = 1'b0;
        d.ackSeen = 1'b0;
        if (startSeen) begin
            d.active = 1'b1;
            d.bitCnt = 4'h0;
            d.drive = 1'b0;
        end else if (stopSeen) begin
            d.active = 1'b0;
            d.drive = 1'b0;
        end else if (q.active && sclRise) begin
            if (q.bitCnt == BIT_ACK) begin
                d.ackSeen = 1'b1;
                d.hostAck = !sdaIn;
                d.bitCnt = 4'h0;
            end else begin
                d.shift = {q.shift[6:0], sdaIn};
                d.bitCnt = q.bitCnt + 4'h1;
                d.byteDone = (q.bitCnt == BIT_LAST);
            end
        end else if (q.active && sclFall) begin
            if (q.bitCnt == BIT_ACK) begin
                d.drive = ackEn;
            end else begin
                d.drive = txMode && !txByte[3'(BIT_LAST - q.bitCnt)];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
            q.sclQ <= 1'b1;
            q.sdaQ <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sdaOut = 1'b0; // open drain: only ever pulls low
    assign sdaOe = q.drive;
    assign byteDone = q.byteDone;
    assign rxByte = q.shift;
    assign ackSeen = q.ackSeen;
    assign hostAck = q.hostAck;

endmodule // smbus_byte_link

// >>> design/clock_gen_config_bytes.sv
// configuration byte bank of the differential clock generator
//
// Behaviour
// - gate bits 3:0 default 1; 1 follows enable pin, 0 forces stop state
// - byte 1 bits 7:6 read back latched spread pin: 00, 01, 11
// - software spread field acts only while override bit 5 is set
// - software spread 00 off, 01 -0.25%, 10 reserved, 11 -0.5%; default 00
// - amplitude 00 0.6V, 01 0.68V, 10 0.75V, 11 0.85V; default 10
// - per-output edge rate bits, 0 slow, 1 fast, default 1
// - reference: edge rate default 01, wake bit default 0, enable default 1
// - byte 5 read-only: revision high nibble, maker code low nibble
// - byte 6 read-only: class code bits 7:6, part code bits 5:0
// - byte 7 bits 4:0 set block read length, default 8
// - bytes 4, 8, 9 and reserved bits have no function
// - stop state: 00 low/low, 01 hi-z, 10 high/low, 11 low/high
// - block write: index, count, then data bytes; every byte acknowledged
// - block read: index, restart, count byte then data; host nack ends
`timescale 1ns/1ps
module clock_gen_config_bytes
    import clkgen_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] spreadPinLevel,
    input wire logic [3:0] outEnPin_n,
    output logic [3:0] diffRun,
    output logic [1:0] diffStopState,
    output logic [1:0] spreadAmount,
    output logic [1:0] ampSelect,
    output logic [3:0] diffEdgeFast,
    output logic [1:0] refEdgeRate,
    output logic refWake,
    output logic refEnable
);

    typedef struct packed {
        xfer_state_t state;
        logic [7:0] idx;
        logic [4:0] remain;
        logic txMode;
        logic [7:0] txByte;
        logic [3:0] gate;
        logic spreadOvr;
        logic [1:0] spreadSw;
        logic [1:0] amp;
        logic [3:0] edgeSel;
        logic [1:0] refRate;
        logic refWakeEn;
        logic refOn;
        logic [4:0] lenField;
        logic [1:0] stopSel;
        logic [1:0] pinLatch;
        logic latchDone;
        logic [3:0] diffRun;
        logic [1:0] spreadAmt;
    } bank_t;

    bank_t q, d;
    logic startSeen, stopSeen, byteDone, ackSeen, hostAck, ackEn;
    logic [7:0] rxByte;

    // ==========================================================
    // serial byte engine
    smbus_byte_link u_link (
        .ref_clk(ref_clk),
        .rst(rst),
        .scl(scl),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .ackEn(ackEn),
        .txMode(q.txMode),
        .txByte(q.txByte),
        .startSeen(startSeen),
        .stopSeen(stopSeen),
        .byteDone(byteDone),
        .rxByte(rxByte),
        .ackSeen(ackSeen),
        .hostAck(hostAck)
    );

    // ==========================================================
    // read view of the bank; unmapped bytes read zero
    function automatic logic [7:0] read_byte(input bank_t b,
                                             input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            OFS_GATE: r = {4'h0, b.gate};
            OFS_SPREAD: r = {b.pinLatch, b.spreadOvr, b.spreadSw, 1'b0,
                             b.amp};
            OFS_EDGE: r = {4'h0, b.edgeSel};
            OFS_REF: r = {b.refRate, b.refWakeEn, b.refOn, 4'h0};
            OFS_IDENT: r = {REVISION_CODE, MAKER_CODE};
            OFS_CLASS: r = {CLASS_CODE, PART_CODE};
            OFS_LEN: r = {3'h0, b.lenField};
            OFS_STOP: r = {6'h00, b.stopSel};
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // device acknowledges each byte it takes in, never its own data
    assign ackEn = !q.txMode && (q.state == ST_INDEX || q.state == ST_COUNT
                   || q.state == ST_WDATA || q.state == ST_RDATA);

    // ==========================================================
    // transaction sequencing and register writes
    always_comb begin
        d = q;
        if (!q.latchDone) begin
            d.pinLatch = spreadPinLevel;
            d.latchDone = 1'b1;
        end
        if (startSeen) begin
            d.state = ST_ADDR;
            d.txMode = 1'b0;
        end else if (stopSeen) begin
            d.state = ST_IDLE;
            d.txMode = 1'b0;
        end else if (byteDone) begin
            case (q.state)
                ST_ADDR: begin
                    if (rxByte[7:1] != SLAVE_ADDR) begin
                        d.state = ST_IGNORE;
                    end else if (rxByte[0]) begin
                        d.state = ST_RDATA;
                    end else begin
                        d.state = ST_INDEX;
                    end
                end
                ST_INDEX: begin
                    d.idx = rxByte;
                    d.state = ST_COUNT;
                end
                ST_COUNT: begin
                    d.remain = rxByte[4:0];
                    d.state = ST_WDATA;
                end
                ST_WDATA: begin
                    // bytes past the announced count are taken but dropped
                    if (q.remain != 5'h00) begin
                        d.remain = q.remain - 5'h01;
                        d.idx = q.idx + 8'h01;
                        case (q.idx)
                            OFS_GATE: d.gate = rxByte[3:0];
                            OFS_SPREAD: begin
                                // bits 7:6 mirror the pin and stay put
                                d.spreadOvr = rxByte[POS_OVR];
                                d.spreadSw =
                                    rxByte[POS_SWAMT_LO +: 2];
                                d.amp = rxByte[POS_AMP_LO +: 2];
                            end
                            OFS_EDGE: d.edgeSel = rxByte[3:0];
                            OFS_REF: begin
                                d.refRate = rxByte[POS_REFRATE_LO +: 2];
                                d.refWakeEn = rxByte[POS_REFWAKE];
                                d.refOn = rxByte[POS_REFEN];
                            end
                            OFS_LEN: d.lenField = rxByte[4:0];
                            OFS_STOP: d.stopSel = rxByte[1:0];
                            default: d.idx = q.idx + 8'h01;
                        endcase
                    end
                end
                default: d.state = q.state;
            endcase
        end else if (ackSeen && q.state == ST_RDATA) begin
            if (!q.txMode) begin
                // address acknowledged: count byte goes out first
                d.txMode = 1'b1;
                d.txByte = {3'h0, q.lenField};
                d.remain = q.lenField;
            end else if (!hostAck) begin
                d.txMode = 1'b0;
                d.state = ST_IGNORE;
            end else if (q.remain != 5'h00) begin
                d.txByte = read_byte(q, q.idx);
                d.idx = q.idx + 8'h01;
                d.remain = q.remain - 5'h01;
            end else begin
                d.txByte = IDLE_BYTE;
            end
        end
        // outputs registered so the analog side sees clean levels
        d.diffRun = q.gate & ~outEnPin_n;
        d.spreadAmt = q.spreadOvr ? q.spreadSw : q.pinLatch;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.gate <= RST_GATE;
            q.spreadOvr <= RST_OVR;
            q.spreadSw <= RST_SWAMT;
            q.amp <= RST_AMP;
            q.edgeSel <= RST_EDGE;
            q.refRate <= RST_REFRATE;
            q.refWakeEn <= RST_REFWAKE;
            q.refOn <= RST_REFEN;
            q.lenField <= RST_LEN;
            q.stopSel <= RST_STOP;
        end else begin
            q <= d;
        end
    end

    assign diffRun = q.diffRun;
    assign diffStopState = q.stopSel;
    assign spreadAmount = q.spreadAmt;
    assign ampSelect = q.amp;
    assign diffEdgeFast = q.edgeSel;
    assign refEdgeRate = q.refRate;
    assign refWake = q.refWakeEn;
    assign refEnable = q.refOn;

    // ==========================================================
    // checks
    AST_GATE_FORCES_STOP: assert property (
        @(posedge ref_clk) disable iff (rst)
        !q.gate[0] |=> !diffRun[0])
        else $error("gated output still runs");
    AST_PIN_HELD: assert property (
        @(posedge ref_clk) disable iff (rst)
        q.latchDone |=> $stable(q.pinLatch))
        else $error("spread pin readback changed");
    // output lags the latch by a cycle, so wait for the latch first
    AST_PIN_SPREAD: assert property (
        @(posedge ref_clk) disable iff (rst)
        (q.latchDone && !q.spreadOvr) ##1 !q.spreadOvr
        |-> spreadAmount == q.pinLatch)
        else $error("spread not under pin control");
    AST_SW_SPREAD: assert property (
        @(posedge ref_clk) disable iff (rst)
        q.spreadOvr ##1 $stable(q.spreadSw) |-> spreadAmount == q.spreadSw)
        else $error("software spread not applied");
    AST_RESET_VALUES: assert property (
        @(posedge ref_clk)
        rst |=> ampSelect == RST_AMP && diffEdgeFast == RST_EDGE
        && refEdgeRate == RST_REFRATE && refEnable == RST_REFEN
        && refWake == RST_REFWAKE && q.lenField == RST_LEN
        && diffStopState == RST_STOP)
        else $error("wrong value after reset");
    AST_COUNT_FIRST: assert property (
        @(posedge ref_clk) disable iff (rst)
        ackSeen && q.state == ST_RDATA && !q.txMode
        |=> q.txMode && q.txByte == {3'h0, q.lenField})
        else $error("block read did not start with count");
    AST_NACK_ENDS: assert property (
        @(posedge ref_clk) disable iff (rst)
        ackSeen && !hostAck && q.txMode && !startSeen && !stopSeen
        |=> !q.txMode && !ackEn)
        else $error("read kept going after nack");
    // a foreign or finished transfer never sees this device pull sda
    AST_NO_ACK_IDLE: assert property (
        @(posedge ref_clk) disable iff (rst)
        q.state == ST_IGNORE || q.state == ST_IDLE |=> !$rose(sdaOe))
        else $error("acknowledge for foreign transfer");

endmodule // clock_gen_config_bytes

// >>> testbench/smbus_host_model.sv
// behavioural serial host for the configuration bank
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic ref_clk,
    input wire logic sdaOe,
    output logic scl,
    output logic sdaIn,
    output logic rxValid,
    output logic [7:0] rxData
);
    logic sdaPull;
    // ==========================================================
    // open drain with pull-up: released line reads high
    assign sdaIn = ~(sdaPull | sdaOe);
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
        rxValid = 1'b0;
        rxData = 8'h00;
    end
    // five cycles keep every wire edge well apart
    task automatic gap();
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic bitIo(input logic b, output logic r);
        sdaPull <= ~b;
        gap();
        scl <= 1'b1;
        gap();
        r = sdaIn;
        scl <= 1'b0;
        gap();
    endtask
    // start and repeated start alike
    task automatic startCond();
        @(posedge ref_clk);
        sdaPull <= 1'b0;
        gap();
        scl <= 1'b1;
        gap();
        sdaPull <= 1'b1;
        gap();
        scl <= 1'b0;
        gap();
    endtask
    task automatic stopCond();
        sdaPull <= 1'b1;
        gap();
        scl <= 1'b1;
        gap();
        sdaPull <= 1'b0;
        gap();
    endtask
    task automatic sendByte(input logic [7:0] b, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(b[i], r);
        end
        bitIo(1'b1, r);
        ok &= ~r;
    endtask
    // last byte gets a nack so the device stops sending
    task automatic recvByte(input logic last);
        logic r;
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 8; i++) begin
            bitIo(1'b1, r);
            d = {d[6:0], r};
        end
        rxData <= d;
        rxValid <= 1'b1;
        @(posedge ref_clk);
        rxValid <= 1'b0;
        bitIo(last, r);
    endtask
    task automatic writeBlock(input logic [6:0] addr, input logic [7:0] idx,
            input logic [7:0] data[$], output logic ok);
        ok = 1'b1;
        startCond();
        sendByte({addr, 1'b0}, ok);
        sendByte(idx, ok);
        sendByte(8'(data.size()), ok);
        foreach (data[i]) begin
            sendByte(data[i], ok);
        end
        stopCond();
    endtask
    // reads the count byte and then n data bytes
    task automatic readBlock(input logic [6:0] addr, input logic [7:0] idx,
            input int n, output logic ok);
        ok = 1'b1;
        startCond();
        sendByte({addr, 1'b0}, ok);
        sendByte(idx, ok);
        startCond();
        sendByte({addr, 1'b1}, ok);
        for (int i = 0; i <= n; i++) begin
            recvByte(i == n);
        end
        stopCond();
    endtask
endmodule // smbus_host_model

// >>> testbench/clock_gen_config_bytes_bench.sv
// self-checking bench of the configuration byte bank
`timescale 1ns/1ps
module clock_gen_config_bytes_bench;
    import clkgen_cfg_pkg::*;
    logic ref_clk;
    logic rst;
    logic [1:0] spreadPinLevel;
    logic [3:0] outEnPin_n;
    logic scl, sdaIn, sdaOe, rxValid, refWake, refEnable, ok;
    logic [3:0] diffRun, diffEdgeFast, gateExp;
    logic [1:0] diffStopState, spreadAmount, ampSelect, refEdgeRate, code;
    logic [7:0] rxData;
    logic [7:0] wq[$];
    logic [15:0] expQ[$];
    logic [15:0] note;
    logic [31:0] rnd;
    int miscompares = 0;
    int samplesChecked = 0;

    clock_gen_config_bytes dut (.ref_clk(ref_clk), .rst(rst), .scl(scl),
        .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe),
        .spreadPinLevel(spreadPinLevel), .outEnPin_n(outEnPin_n),
        .diffRun(diffRun), .diffStopState(diffStopState),
        .spreadAmount(spreadAmount), .ampSelect(ampSelect),
        .diffEdgeFast(diffEdgeFast), .refEdgeRate(refEdgeRate),
        .refWake(refWake), .refEnable(refEnable));
    smbus_host_model host (.ref_clk(ref_clk), .sdaOe(sdaOe), .scl(scl),
        .sdaIn(sdaIn), .rxValid(rxValid), .rxData(rxData));

    // ==========================================================
    // helpers
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // reserved bits are masked out, their values mean nothing
    task automatic noteExp(input logic [7:0] m, input logic [7:0] d);
        expQ.push_back({m, d & m});
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watcher: each received byte against the oldest note
    always @(posedge ref_clk) begin
        if (rxValid === 1'b1) begin
            if (expQ.size() == 0) begin
                miscompares++;
                $display("BAD t=%0t byte without a note", $time);
            end else begin
                note = expQ.pop_front();
                chk(rxData & note[15:8], note[7:0]);
            end
        end
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        $display("BAD t=%0t run did not finish", $time);
        finalReport();
    end

    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        spreadPinLevel = 2'b11;
        outEnPin_n = 4'h0;
        rnd = 32'h2b3f;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        spreadPinLevel <= 2'b00; // latched already, must not show
        settle();
        chk(8'(diffRun), 8'h0f);
        chk(8'(diffStopState), 8'h00);
        chk(8'(spreadAmount), 8'h03);
        chk(8'(ampSelect), 8'h02);
        chk(8'(diffEdgeFast), 8'h0f);
        chk(8'({refEdgeRate, refWake, refEnable}), 8'h05);
        noteExp(8'h1f, 8'h08);
        noteExp(8'h0f, 8'h0f);
        noteExp(8'hfb, 8'hc2);
        noteExp(8'h0f, 8'h0f);
        noteExp(8'hf0, 8'h50);
        noteExp(8'h00, 8'h00);
        noteExp(8'hff, {REVISION_CODE, MAKER_CODE});
        noteExp(8'hff, {CLASS_CODE, PART_CODE});
        noteExp(8'h1f, 8'h08);
        host.readBlock(SLAVE_ADDR, OFS_GATE, 8, ok);
        chk(8'(ok), 8'h01);
        // random block write over bytes 0 to 3; the pin field is written
        // as 00 with override off, so the latched high level must remain
        rnd = lfsr(rnd);
        gateExp = rnd[3:0];
        @(posedge ref_clk);
        outEnPin_n <= rnd[15:12];
        wq = '{{4'h0, rnd[3:0]}, 8'h09, {4'h0, rnd[7:4]},
            {rnd[9:8], rnd[10], rnd[11], 4'h0}};
        host.writeBlock(SLAVE_ADDR, OFS_GATE, wq, ok);
        settle();
        chk(8'(ok), 8'h01);
        chk(8'(diffRun), 8'(gateExp & ~outEnPin_n));
        chk(8'(spreadAmount), 8'h03);
        chk(8'(diffEdgeFast), 8'(rnd[7:4]));
        chk(8'({refEdgeRate, refWake, refEnable}),
            8'({rnd[9:8], rnd[10], rnd[11]}));
        // every amplitude code, and every software spread code but reserved 10, under override
        for (int i = 0; i < 4; i++) begin
            code = 2'(i);
            wq = '{{3'b001, code, 1'b0, code}};
            host.writeBlock(SLAVE_ADDR, OFS_SPREAD, wq, ok);
            settle();
            chk(8'(ampSelect), 8'(code));
            if (code != 2'b10) begin
                chk(8'(spreadAmount), 8'(code));
            end
        end
        wq = '{8'h02};
        host.writeBlock(SLAVE_ADDR, OFS_SPREAD, wq, ok);
        settle();
        chk(8'(spreadAmount), 8'h03);
        // every stop state, enable pins moving meanwhile
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            @(posedge ref_clk);
            outEnPin_n <= rnd[3:0];
            wq = '{8'(i)};
            host.writeBlock(SLAVE_ADDR, OFS_STOP, wq, ok);
            settle();
            chk(8'(diffStopState), 8'(i));
            chk(8'(diffRun), 8'(gateExp & ~outEnPin_n));
        end
        // writes to fixed codes dropped, length shortened to 3
        wq = '{8'h00, 8'h00, 8'h03};
        host.writeBlock(SLAVE_ADDR, OFS_IDENT, wq, ok);
        noteExp(8'h1f, 8'h03);
        noteExp(8'hff, {REVISION_CODE, MAKER_CODE});
        noteExp(8'hff, {CLASS_CODE, PART_CODE});
        noteExp(8'h1f, 8'h03);
        // one byte past the count: device lets the line float high
        noteExp(8'hff, 8'hff);
        host.readBlock(SLAVE_ADDR, OFS_IDENT, 4, ok);
        chk(8'(ok), 8'h01);
        // other address: no acknowledge, nothing written
        wq = '{8'h00};
        host.writeBlock(SLAVE_ADDR ^ 7'h01, OFS_GATE, wq, ok);
        settle();
        chk(8'(ok), 8'h00);
        chk(8'(diffRun), 8'(gateExp & ~outEnPin_n));
        chk(8'(expQ.size()), 8'h00);
        finalReport();
    end
endmodule // clock_gen_config_bytes_bench
